// File: core/programmable_fir.sv
// How it works
// - Optional FIR on samples; bypass passes unfiltered
// - Mode 0 off; mode 2 with share/merge selects
// - Dual equalization only in dual-channel format
// - Each channel has own nine coefficients
// - Center tap 18 bits, LSB 2^-16
// - Side taps 12 bits, weight 2^-10..2^-16
// - One weight setting shared by side taps
// - Single equalization only in single-channel format
// - Time-varying needs single-channel, dual-input
// - Time-varying alternates sets every sample
// - Each alternating set holds nine coefficients
// - Banks A and B hold coefficients
//
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
module programmable_fir #(
   parameter int SAMPLE_W = fir_eq_pkg::SAMPLE_W,
   parameter int NUM_TAPS = fir_eq_pkg::NUM_TAPS
) (
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   input  wire logic [fir_eq_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   input  wire logic [31:0]                s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   output logic [1:0]                      s_axi_bresp,
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   input  wire logic [fir_eq_pkg::ADDR_W-1:0] s_axi_araddr,
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready,
   output logic [31:0]                     s_axi_rdata,
   output logic [1:0]                      s_axi_rresp,
   input  wire logic                       in_valid,
   output logic                            in_ready,
   input  wire logic [SAMPLE_W-1:0]        in_a,
   input  wire logic [SAMPLE_W-1:0]        in_b,
   output logic                            out_valid,
   input  wire logic                       out_ready,
   output logic [SAMPLE_W-1:0]             out_a,
   output logic [SAMPLE_W-1:0]             out_b
);
   localparam int CW = fir_eq_pkg::CENTER_W;
   localparam int AW = fir_eq_pkg::ADDR_W;
   localparam int BANK_SPAN = 4 * NUM_TAPS;

   // Bus and register state
   logic              awready_ff, nxt_awready;
   logic              wready_ff, nxt_wready;
   logic              bvalid_ff, nxt_bvalid;
   logic [1:0]        bresp_ff, nxt_bresp;
   logic [AW-1:0]     waddr_ff, nxt_waddr;
   logic [31:0]       wdata_ff, nxt_wdata;
   logic [3:0]        wstrb_ff, nxt_wstrb;
   logic              arready_ff, nxt_arready;
   logic              rvalid_ff, nxt_rvalid;
   logic [31:0]       rdata_ff, nxt_rdata;
   logic [1:0]        rresp_ff, nxt_rresp;
   logic [31:0]       ctrl_ff, nxt_ctrl;
   logic [31:0]       link_ff, nxt_link;
   logic [CW-1:0]     bank_a_ff [NUM_TAPS];
   logic [CW-1:0]     nxt_bank_a [NUM_TAPS];
   logic [CW-1:0]     bank_b_ff [NUM_TAPS];
   logic [CW-1:0]     nxt_bank_b [NUM_TAPS];
   logic              refused_ff, nxt_refused;

   // Stream state
   logic [SAMPLE_W-1:0] hist_a_ff [NUM_TAPS];
   logic [SAMPLE_W-1:0] nxt_hist_a [NUM_TAPS];
   logic [SAMPLE_W-1:0] hist_b_ff [NUM_TAPS];
   logic [SAMPLE_W-1:0] nxt_hist_b [NUM_TAPS];
   logic                phase_ff, nxt_phase;
   logic                in_ready_ff, nxt_in_ready;
   logic                out_valid_ff, nxt_out_valid;
   logic [SAMPLE_W-1:0] out_a_ff, nxt_out_a;
   logic [SAMPLE_W-1:0] out_b_ff, nxt_out_b;
   logic                skid_valid_ff, nxt_skid_valid;
   logic [SAMPLE_W-1:0] skid_a_ff, nxt_skid_a;
   logic [SAMPLE_W-1:0] skid_b_ff, nxt_skid_b;

   fir_eq_pkg::active_t active;
   logic [2:0]          weight;
   logic [SAMPLE_W-1:0] res_a, res_b;
   logic                accept, pop;

   function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                               input logic [31:0] data,
                                               input logic [3:0]  strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (strb[i])
            r[i*8 +: 8] = data[i*8 +: 8];
      return r;
   endfunction

   // Tap index of an address inside a bank, or NUM_TAPS when outside
   function automatic int tap_index(input logic [AW-1:0] addr,
                                    input logic [AW-1:0] base);
      if (addr >= base && int'(addr) < int'(base) + BANK_SPAN
          && addr[1:0] == 2'b00)
         return (int'(addr) - int'(base)) / 4;
      return NUM_TAPS;
   endfunction

   // Accumulates in units of 2^-16 so center and side taps share one sum
   function automatic logic [SAMPLE_W-1:0] fir_sum(
         input logic [SAMPLE_W-1:0] h [NUM_TAPS],
         input logic [CW-1:0]       c [NUM_TAPS],
         input logic [2:0]          w);
      logic signed [fir_eq_pkg::ACC_W-1:0] acc;
      logic signed [fir_eq_pkg::ACC_W-1:0] p;
      logic signed [fir_eq_pkg::ACC_W-1:0] hi;
      logic signed [fir_eq_pkg::ACC_W-1:0] lo;
      acc = fir_eq_pkg::ACC_W'(1) <<< (fir_eq_pkg::FRAC_BITS - 1);
      hi  = fir_eq_pkg::ACC_W'((1 << (SAMPLE_W - 1)) - 1);
      lo  = -(fir_eq_pkg::ACC_W'(1) <<< (SAMPLE_W - 1));
      for (int k = 0; k < NUM_TAPS; k++)
      begin
         if (k == fir_eq_pkg::CENTER_TAP)
            p = $signed(h[k]) * $signed(c[k]);
         else
            p = ($signed(h[k]) * $signed(c[k][fir_eq_pkg::SIDE_W-1:0]))
                <<< (fir_eq_pkg::WEIGHT_MAX - w);
         acc = acc + p;
      end
      acc = acc >>> fir_eq_pkg::FRAC_BITS;
      if (acc > hi)
         acc = hi;
      else if (acc < lo)
         acc = lo;
      return acc[SAMPLE_W-1:0];
   endfunction

   // Mode decode; an illegal pairing with the link format falls to bypass
   always_comb
   begin
      logic on, share, merge, dual_ch, dual_in;
      on      = ctrl_ff[fir_eq_pkg::MODE_LSB +: 2] == fir_eq_pkg::MODE_ON;
      share   = ctrl_ff[fir_eq_pkg::SHARE_BIT];
      merge   = ctrl_ff[fir_eq_pkg::MERGE_BIT];
      dual_ch = link_ff[fir_eq_pkg::DUAL_BIT];
      dual_in = link_ff[fir_eq_pkg::INPUT_BIT];
      active  = fir_eq_pkg::ACT_BYPASS;
      if (on && !share && !merge && dual_ch)
         active = fir_eq_pkg::ACT_DUAL;
      else if (on && share && merge && !dual_ch)
         active = fir_eq_pkg::ACT_SINGLE;
      else if (on && !share && merge && !dual_ch && dual_in)
         active = fir_eq_pkg::ACT_VARYING;
      weight = ctrl_ff[fir_eq_pkg::WEIGHT_LSB +: 3];
      if (weight > fir_eq_pkg::WEIGHT_MAX)
         weight = fir_eq_pkg::WEIGHT_MAX;
      nxt_refused = on && active == fir_eq_pkg::ACT_BYPASS;
   end

   // AXI4-Lite slave and register file
   always_comb
   begin
      int ia, ib, ra, rb;
      ia = tap_index(waddr_ff, fir_eq_pkg::BANK_A_ADDR);
      ib = tap_index(waddr_ff, fir_eq_pkg::BANK_B_ADDR);
      ra = tap_index(s_axi_araddr, fir_eq_pkg::BANK_A_ADDR);
      rb = tap_index(s_axi_araddr, fir_eq_pkg::BANK_B_ADDR);
      nxt_awready = awready_ff;
      nxt_wready  = wready_ff;
      nxt_bvalid  = bvalid_ff;
      nxt_bresp   = bresp_ff;
      nxt_waddr   = waddr_ff;
      nxt_wdata   = wdata_ff;
      nxt_wstrb   = wstrb_ff;
      nxt_arready = arready_ff;
      nxt_rvalid  = rvalid_ff;
      nxt_rdata   = rdata_ff;
      nxt_rresp   = rresp_ff;
      nxt_ctrl    = ctrl_ff;
      nxt_link    = link_ff;
      nxt_bank_a  = bank_a_ff;
      nxt_bank_b  = bank_b_ff;
      if (s_axi_awvalid && awready_ff)
      begin
         nxt_awready = 1'b0;
         nxt_waddr   = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_ff)
      begin
         nxt_wready = 1'b0;
         nxt_wdata  = s_axi_wdata;
         nxt_wstrb  = s_axi_wstrb;
      end
      // Both halves held: commit the write and answer in the same edge
      if (!awready_ff && !wready_ff && !bvalid_ff)
      begin
         nxt_bvalid = 1'b1;
         nxt_bresp  = fir_eq_pkg::RESP_OK;
         if (waddr_ff == fir_eq_pkg::CTRL_ADDR)
            nxt_ctrl = merge_bytes(ctrl_ff, wdata_ff, wstrb_ff);
         else if (waddr_ff == fir_eq_pkg::LINK_ADDR)
            nxt_link = merge_bytes(link_ff, wdata_ff, wstrb_ff);
         else if (ia < NUM_TAPS)
            nxt_bank_a[ia] = CW'(merge_bytes(32'(bank_a_ff[ia]),
                                             wdata_ff, wstrb_ff));
         else if (ib < NUM_TAPS)
            nxt_bank_b[ib] = CW'(merge_bytes(32'(bank_b_ff[ib]),
                                             wdata_ff, wstrb_ff));
         else if (waddr_ff != fir_eq_pkg::STATUS_ADDR)
            nxt_bresp = fir_eq_pkg::RESP_ERR;
      end
      if (bvalid_ff && s_axi_bready)
      begin
         nxt_bvalid  = 1'b0;
         nxt_awready = 1'b1;
         nxt_wready  = 1'b1;
      end
      if (s_axi_arvalid && arready_ff)
      begin
         nxt_arready = 1'b0;
         nxt_rvalid  = 1'b1;
         nxt_rresp   = fir_eq_pkg::RESP_OK;
         nxt_rdata   = 32'h0000_0000;
         if (s_axi_araddr == fir_eq_pkg::CTRL_ADDR)
            nxt_rdata = ctrl_ff;
         else if (s_axi_araddr == fir_eq_pkg::LINK_ADDR)
            nxt_rdata = link_ff;
         else if (s_axi_araddr == fir_eq_pkg::STATUS_ADDR)
            nxt_rdata = {29'h0000_0000, refused_ff, 2'(active)};
         else if (ra < NUM_TAPS)
            nxt_rdata = 32'(bank_a_ff[ra]);
         else if (rb < NUM_TAPS)
            nxt_rdata = 32'(bank_b_ff[rb]);
         else
            nxt_rresp = fir_eq_pkg::RESP_ERR;
      end
      if (rvalid_ff && s_axi_rready)
      begin
         nxt_rvalid  = 1'b0;
         nxt_arready = 1'b1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready_ff <= 1'b1;
         wready_ff  <= 1'b1;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= fir_eq_pkg::RESP_OK;
         waddr_ff   <= '0;
         wdata_ff   <= 32'h0000_0000;
         wstrb_ff   <= 4'h0;
         arready_ff <= 1'b1;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= 32'h0000_0000;
         rresp_ff   <= fir_eq_pkg::RESP_OK;
         ctrl_ff    <= fir_eq_pkg::CTRL_RST;
         link_ff    <= fir_eq_pkg::LINK_RST;
         refused_ff <= 1'b0;
         for (int k = 0; k < NUM_TAPS; k++)
         begin
            bank_a_ff[k] <= fir_eq_pkg::COEF_RST;
            bank_b_ff[k] <= fir_eq_pkg::COEF_RST;
         end
      end
      else
      begin
         awready_ff <= nxt_awready;
         wready_ff  <= nxt_wready;
         bvalid_ff  <= nxt_bvalid;
         bresp_ff   <= nxt_bresp;
         waddr_ff   <= nxt_waddr;
         wdata_ff   <= nxt_wdata;
         wstrb_ff   <= nxt_wstrb;
         arready_ff <= nxt_arready;
         rvalid_ff  <= nxt_rvalid;
         rdata_ff   <= nxt_rdata;
         rresp_ff   <= nxt_rresp;
         ctrl_ff    <= nxt_ctrl;
         link_ff    <= nxt_link;
         refused_ff <= nxt_refused;
         bank_a_ff  <= nxt_bank_a;
         bank_b_ff  <= nxt_bank_b;
      end
   end

   // Filter datapath and two-entry output buffer
   assign accept = in_valid && in_ready_ff;
   assign pop    = out_valid_ff && out_ready;

   always_comb
   begin
      nxt_hist_a = hist_a_ff;
      nxt_hist_b = hist_b_ff;
      nxt_phase  = phase_ff;
      if (accept)
      begin
         for (int k = NUM_TAPS - 1; k > 0; k--)
         begin
            nxt_hist_a[k] = hist_a_ff[k-1];
            nxt_hist_b[k] = hist_b_ff[k-1];
         end
         nxt_hist_a[0] = in_a;
         nxt_hist_b[0] = in_b;
      end
      // Set select restarts on bank A whenever the mode is left
      if (active != fir_eq_pkg::ACT_VARYING)
         nxt_phase = 1'b0;
      else if (accept)
         nxt_phase = !phase_ff;
      res_a = in_a;
      res_b = in_b;
      case (active)
         fir_eq_pkg::ACT_DUAL:
         begin
            res_a = fir_sum(nxt_hist_a, bank_a_ff, weight);
            res_b = fir_sum(nxt_hist_b, bank_b_ff, weight);
         end
         fir_eq_pkg::ACT_SINGLE:
            res_a = fir_sum(nxt_hist_a, bank_a_ff, weight);
         fir_eq_pkg::ACT_VARYING:
            res_a = phase_ff ? fir_sum(nxt_hist_a, bank_b_ff, weight)
                             : fir_sum(nxt_hist_a, bank_a_ff, weight);
         default:
         begin
            res_a = in_a;
            res_b = in_b;
         end
      endcase
   end

   // A stalled receiver fills the skid slot, then in_ready drops
   always_comb
   begin
      nxt_out_valid  = out_valid_ff && !pop;
      nxt_out_a      = out_a_ff;
      nxt_out_b      = out_b_ff;
      nxt_skid_valid = skid_valid_ff;
      nxt_skid_a     = skid_a_ff;
      nxt_skid_b     = skid_b_ff;
      if (skid_valid_ff && pop)
      begin
         nxt_out_valid  = 1'b1;
         nxt_out_a      = skid_a_ff;
         nxt_out_b      = skid_b_ff;
         nxt_skid_valid = 1'b0;
      end
      else if (accept && out_valid_ff && !pop)
      begin
         nxt_skid_valid = 1'b1;
         nxt_skid_a     = res_a;
         nxt_skid_b     = res_b;
      end
      else if (accept)
      begin
         nxt_out_valid = 1'b1;
         nxt_out_a     = res_a;
         nxt_out_b     = res_b;
      end
      nxt_in_ready = !nxt_skid_valid;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         for (int k = 0; k < NUM_TAPS; k++)
         begin
            hist_a_ff[k] <= '0;
            hist_b_ff[k] <= '0;
         end
         phase_ff      <= 1'b0;
         in_ready_ff   <= 1'b0;
         out_valid_ff  <= 1'b0;
         out_a_ff      <= '0;
         out_b_ff      <= '0;
         skid_valid_ff <= 1'b0;
         skid_a_ff     <= '0;
         skid_b_ff     <= '0;
      end
      else
      begin
         hist_a_ff     <= nxt_hist_a;
         hist_b_ff     <= nxt_hist_b;
         phase_ff      <= nxt_phase;
         in_ready_ff   <= nxt_in_ready;
         out_valid_ff  <= nxt_out_valid;
         out_a_ff      <= nxt_out_a;
         out_b_ff      <= nxt_out_b;
         skid_valid_ff <= nxt_skid_valid;
         skid_a_ff     <= nxt_skid_a;
         skid_b_ff     <= nxt_skid_b;
      end
   end

   assign s_axi_awready = awready_ff;
   assign s_axi_wready  = wready_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rdata   = rdata_ff;
   assign s_axi_rresp   = rresp_ff;
   assign in_ready      = in_ready_ff;
   assign out_valid     = out_valid_ff;
   assign out_a         = out_a_ff;
   assign out_b         = out_b_ff;

endmodule // programmable_fir

// File: common/fir_eq_pkg.sv
package fir_eq_pkg;
   // Stream and coefficient geometry
   localparam int SAMPLE_W    = 8;
   localparam int NUM_TAPS    = 9;
   localparam int CENTER_TAP  = 4;
   localparam int CENTER_W    = 18;
   localparam int SIDE_W      = 12;
   localparam int ACC_W       = 32;
   localparam int FRAC_BITS   = 16;
   localparam logic [2:0] WEIGHT_MAX = 3'h6;
   // Register byte addresses
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] CTRL_ADDR   = 8'h00;
   localparam logic [ADDR_W-1:0] LINK_ADDR   = 8'h04;
   localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h08;
   localparam logic [ADDR_W-1:0] BANK_A_ADDR = 8'h40;
   localparam logic [ADDR_W-1:0] BANK_B_ADDR = 8'h80;
   // Control and link fields, codes and reset values
   localparam int MODE_LSB   = 0;
   localparam int SHARE_BIT  = 4;
   localparam int MERGE_BIT  = 5;
   localparam int WEIGHT_LSB = 8;
   localparam int DUAL_BIT   = 0;
   localparam int INPUT_BIT  = 1;
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_ON  = 2'h2;
   localparam logic [1:0] RESP_OK  = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] LINK_RST = 32'h0000_0001;
   localparam logic [CENTER_W-1:0] COEF_RST = 18'h0_0000;
   typedef enum logic [1:0] {
      ACT_BYPASS,
      ACT_DUAL,
      ACT_SINGLE,
      ACT_VARYING
   } active_t;
endpackage

// File: tb/programmable_fir_chk.sv
module programmable_fir_chk #(
   parameter int SAMPLE_W = 8
) (
   input wire logic                           aclk,
   input wire logic                           aresetn,
   input wire logic                           s_axi_awvalid,
   input wire logic                           s_axi_awready,
   input wire logic [fir_eq_pkg::ADDR_W-1:0]  s_axi_awaddr,
   input wire logic                           s_axi_bvalid,
   input wire logic                           s_axi_bready,
   input wire logic [1:0]                     s_axi_bresp,
   input wire logic                           s_axi_arvalid,
   input wire logic                           s_axi_arready,
   input wire logic [fir_eq_pkg::ADDR_W-1:0]  s_axi_araddr,
   input wire logic                           s_axi_rvalid,
   input wire logic                           s_axi_rready,
   input wire logic [31:0]                    s_axi_rdata,
   input wire logic [1:0]                     s_axi_rresp,
   input wire logic                           in_valid,
   input wire logic                           in_ready,
   input wire logic                           out_valid,
   input wire logic                           out_ready,
   input wire logic [SAMPLE_W-1:0]            out_a,
   input wire logic [SAMPLE_W-1:0]            out_b
);
   logic [7:0] wa_ff, nxt_wa, ra_ff, nxt_ra;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   function automatic logic mapped(input logic [7:0] ad);
      return ad[1:0] == 2'h0 && (ad <= 8'h08 || (ad >= 8'h40 && ad <= 8'h60)
         || (ad >= 8'h80 && ad <= 8'ha0));
   endfunction
   // Remember the address of the access now under way
   always_comb
   begin
      nxt_wa = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : wa_ff;
      nxt_ra = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : ra_ff;
   end
   always_ff @(posedge aclk)
   begin
      wa_ff <= nxt_wa;
      ra_ff <= nxt_ra;
   end
   a_bresp_hold:
      assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
         && $stable(s_axi_bresp)) else $error("write answer dropped");
   a_rdata_hold:
      assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
         && $stable(s_axi_rdata)) else $error("read answer dropped");
   a_read_answer:
      assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_write_code:
      assert property (s_axi_bvalid |-> s_axi_bresp == (mapped(wa_ff) ?
         fir_eq_pkg::RESP_OK : fir_eq_pkg::RESP_ERR)) else $error("bresp");
   a_read_unmapped:
      assert property (s_axi_rvalid && !mapped(ra_ff) |-> s_axi_rdata == 0
         && s_axi_rresp == fir_eq_pkg::RESP_ERR) else $error("bad read");
   a_coef_width:
      assert property (s_axi_rvalid && ra_ff >= 8'h40 && mapped(ra_ff)
         |-> s_axi_rdata[31:18] == 0) else $error("coefficient too wide");
   a_out_hold:
      assert property (out_valid && !out_ready |=> out_valid
         && $stable({out_a, out_b})) else $error("output lost");
   a_out_follows:
      assert property (in_valid && in_ready && (!out_valid || out_ready)
         |=> out_valid) else $error("output late");
   a_ready_drop:
      assert property ($fell(in_ready) |-> $past(out_valid && !out_ready))
      else $error("input refused without stall");
endmodule // programmable_fir_chk

bind programmable_fir programmable_fir_chk #(.SAMPLE_W(SAMPLE_W)) chk (
   .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
   .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
   .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
   .s_axi_rdata, .s_axi_rresp, .in_valid, .in_ready, .out_valid,
   .out_ready, .out_a, .out_b
);

// File: tb/fir_stream_partner.sv
module fir_stream_partner (
   input wire logic  aclk,
   input wire logic  in_ready,
   input wire logic  out_valid,
   input wire logic [7:0] out_a,
   input wire logic [7:0] out_b,
   output logic      in_valid,
   output logic [7:0] in_a,
   output logic [7:0] in_b,
   output logic      out_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] tx_q[$];
   logic [15:0] rx_q[$];
   logic [15:0] pr;
   bit          stall;
   initial
   begin
      in_valid = 1'b0;
      in_a = 8'h00;
      in_b = 8'h00;
      out_ready = 1'b0;
   end
   always @(posedge aclk)
   begin
      if (!in_valid || in_ready)
      begin
         if (tx_q.size() > 0)
         begin
            pr = tx_q.pop_front();
            in_valid <= 1'b1;
            in_a <= pr[15:8];
            in_b <= pr[7:0];
         end
         else
         begin
            // Idle lines churn so stale data is never mistaken for a sample
            in_valid <= 1'b0;
            in_a <= ~in_a;
            in_b <= ~in_b;
         end
      end
      if (out_valid && out_ready)
         rx_q.push_back({out_a, out_b});
      out_ready <= !stall;
   end
endmodule // fir_stream_partner

// File: tb/test_programmable_fir.sv
module test_programmable_fir;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic in_valid, in_ready, out_valid, out_ready;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, in_a, in_b, out_a, out_b;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   int          ca[9], cb[9], ha[9], hb[9];
   int          wsel, act, phase, err_count, samples_checked;
   logic [15:0] exp_q[$];
   logic [31:0] bad_ctl[6] = '{32'h32, 32'h2, 32'h22, 32'h22, 32'h1, 32'h33};
   logic [31:0] bad_lnk[6] = '{32'h1, 32'h0, 32'h0, 32'h1, 32'h1, 32'h1};
   programmable_fir dut (
      .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
      .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
      .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
      .s_axi_rdata, .s_axi_rresp, .in_valid, .in_ready, .in_a, .in_b,
      .out_valid, .out_ready, .out_a, .out_b
   );
   fir_stream_partner part (
      .aclk, .in_ready, .out_valid, .out_a, .out_b, .in_valid, .in_a,
      .in_b, .out_ready
   );
   initial
   begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tally_and_finish();
      $display("Checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic axw(input logic [7:0] ad, input logic [31:0] d,
                      input logic [1:0] er = fir_eq_pkg::RESP_OK,
                      input logic [3:0] st = 4'hf);
      int n;
      @(posedge aclk);
      s_axi_awvalid <= 1'b1;
      s_axi_awaddr <= ad;
      s_axi_wvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= st;
      n = 0;
      do
      begin
         @(posedge aclk);
         n++;
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 99);
      s_axi_bready <= 1'b1;
      @(posedge aclk);
      s_axi_bready <= 1'b0;
      if (n >= 99)
         err_count++;
      if (n >= 99)
         tally_and_finish();
      chk("bresp", er, s_axi_bresp);
   endtask
   task automatic axr(input logic [7:0] ad, input logic [31:0] ed,
                      input logic [1:0] er = fir_eq_pkg::RESP_OK);
      int n;
      @(posedge aclk);
      s_axi_arvalid <= 1'b1;
      s_axi_araddr <= ad;
      n = 0;
      do
      begin
         @(posedge aclk);
         n++;
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 99);
      s_axi_rready <= 1'b1;
      @(posedge aclk);
      s_axi_rready <= 1'b0;
      if (n >= 99)
         err_count++;
      if (n >= 99)
         tally_and_finish();
      chk("rresp", er, s_axi_rresp);
      chk("rdata", ed, s_axi_rdata);
   endtask
   // Sum kept in 2^-16 units; side taps scaled by the shared weight
   function automatic logic [7:0] fir(input int c[9], input int h[9]);
      int s;
      s = 0;
      for (int k = 0; k < 9; k++)
         s += (k == 4) ? c[k] * h[k]
                       : (c[k] * h[k]) <<< (6 - (wsel > 6 ? 6 : wsel));
      s = (s + 32768) >>> 16;
      return (s > 127) ? 8'h7f : (s < -128) ? 8'h80 : s[7:0];
   endfunction
   task automatic send(input logic [7:0] a, input logic [7:0] b);
      logic [7:0] ea, eb;
      for (int k = 8; k > 0; k--)
      begin
         ha[k] = ha[k-1];
         hb[k] = hb[k-1];
      end
      ha[0] = $signed(a);
      hb[0] = $signed(b);
      ea = (act == 0) ? a : (act == 3 && phase) ? fir(cb, ha) : fir(ca, ha);
      eb = (act == 1) ? fir(cb, hb) : b;
      phase ^= (act == 3);
      part.tx_q.push_back({a, b});
      exp_q.push_back({ea, eb});
   endtask
   task automatic drain();
      int n;
      n = 0;
      while (part.rx_q.size() < exp_q.size() && n < 2000)
      begin
         @(posedge aclk);
         n++;
      end
      if (n >= 2000)
         err_count++;
      if (n >= 2000)
         tally_and_finish();
      while (exp_q.size() > 0)
         chk("sample", exp_q.pop_front(), part.rx_q.pop_front());
   endtask
   task automatic burst();
      for (int k = 0; k < 12; k++)
         send(8'(k * 53 + 17), 8'(k * 91 + 5));
      drain();
   endtask
   task automatic mode(input logic [31:0] ctl, input logic [31:0] lnk,
                       input logic [1:0] ac, input logic il);
      axw(fir_eq_pkg::LINK_ADDR, lnk);
      axw(fir_eq_pkg::CTRL_ADDR, ctl);
      act = ac;
      wsel = ctl[10:8];
      phase = 0;
      axr(fir_eq_pkg::STATUS_ADDR, {29'h0, il, ac});
      repeat (9) send(8'h00, 8'h00);
      drain();
   endtask
   initial
   begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
      s_axi_wdata = 32'h0000_0000;
      s_axi_wstrb = 4'hf;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      axr(fir_eq_pkg::CTRL_ADDR, fir_eq_pkg::CTRL_RST);
      axr(fir_eq_pkg::LINK_ADDR, fir_eq_pkg::LINK_RST);
      axr(8'h50, 32'h0000_0000);
      axr(8'h42, 32'h0000_0000, fir_eq_pkg::RESP_ERR);
      axw(8'hc0, 32'hffff_ffff, fir_eq_pkg::RESP_ERR);
      axw(fir_eq_pkg::STATUS_ADDR, 32'hffff_ffff);
      // Byte strobes merge, and bits above the coefficient width drop
      axw(8'h44, 32'hffff_ffff, fir_eq_pkg::RESP_OK, 4'h6);
      axr(8'h44, 32'h0003_ff00);
      for (int k = 0; k < 9; k++)
      begin
         ca[k] = (k == 4) ? 40000 : k * 300 - 1200;
         cb[k] = (k == 4) ? -30000 : 900 - k * 200;
         axw(8'h40 + 8'(4 * k), ca[k]);
         axw(8'h80 + 8'(4 * k), cb[k]);
         axr(8'h40 + 8'(4 * k), ca[k] & 32'h0003_ffff);
         axr(8'h80 + 8'(4 * k), cb[k] & 32'h0003_ffff);
      end
      $display("Test registers done");
      for (int w = 0; w < 8; w++)
      begin
         mode(32'h2 | (w << 8), 32'h1, 2'h1, 1'b0);
         burst();
      end
      $display("Test dual done");
      mode(32'h0000_0532, 32'h0, 2'h2, 1'b0);
      burst();
      mode(32'h0000_0222, 32'h2, 2'h3, 1'b0);
      burst();
      $display("Test single and varying done");
      for (int i = 0; i < 6; i++)
      begin
         mode(bad_ctl[i], bad_lnk[i], 2'h0, i < 4);
         burst();
      end
      $display("Test refused modes done");
      mode(32'h0000_0030, 32'h1, 2'h0, 1'b0);
      part.stall = 1'b1;
      repeat (3) @(posedge aclk);
      for (int k = 0; k < 4; k++)
         send(8'(k * 77 + 3), 8'(200 - k));
      repeat (20) @(posedge aclk);
      chk("taken", 2, 4 - part.tx_q.size() - in_valid);
      chk("in_ready", 0, in_ready);
      part.stall = 1'b0;
      drain();
      $display("Test stall done");
      tally_and_finish();
   end
endmodule // test_programmable_fir
